// [shared/srfc_pkg.sv]
// Constants, types and phase-role helpers for the sensorless flux commutation block.
// Assumes one 20 MHz core clock and one step per PWM period, marked by a centre strobe.
`default_nettype none
package srfc_pkg;
	localparam int ADC_W = 12;
	localparam logic [11:0] ADC_MID = 12'h800;
	localparam int CUR_W = 14;
	localparam int DUTY_W = 12;
	localparam logic [11:0] DUTY_ONE = 12'hfff;
	localparam int VOLT_W = 13;
	localparam int FLUX_W = 24;
	localparam int RES_W = 16;
	localparam int RES_FRAC = 8;
	localparam logic [15:0] RES_INIT = 16'h0100;
	// Resistance trim step of 0.1 percent, held as parts per million and as a Q20 factor.
	localparam int RES_STEP_PPM = 1000;
	localparam int RES_STEP_Q20 = ((2 ** 20) * RES_STEP_PPM) / 1000000;
	localparam int ANG_W = 8;
	localparam logic [10:0] ANGLE_BASE = 11'h040;
	localparam int ANG_CNT_W = 4;
	localparam logic [3:0] ANGLE_PERIOD = 4'hf;
	localparam logic signed [13:0] I_ZERO_THR = 14'sh0010;
	localparam int BUS_AVG_LOG2 = 3;
	localparam int ERR_AVG_LOG2 = 2;
	localparam logic [12:0] TEMP_OFFSET = 13'h0200;
	localparam int TEMP_SLOPE = 5;
	localparam logic [1:0] PH_A = 2'h0;
	localparam logic [1:0] PH_B = 2'h1;
	localparam logic [1:0] PH_C = 2'h2;

	typedef enum logic [1:0] {STEP_C, STEP_B, STEP_A} srfc_step_t;

	// Roles per step of the C, B, A sequence: active, discharging and unpowered reference.
	function automatic logic [1:0] srfc_act(input srfc_step_t s);
		return (s == STEP_C) ? PH_C : (s == STEP_B) ? PH_B : PH_A;
	endfunction : srfc_act

	function automatic logic [1:0] srfc_dis(input srfc_step_t s);
		return (s == STEP_C) ? PH_A : (s == STEP_B) ? PH_C : PH_B;
	endfunction : srfc_dis

	function automatic logic [1:0] srfc_ref(input srfc_step_t s);
		return (s == STEP_C) ? PH_B : (s == STEP_B) ? PH_A : PH_C;
	endfunction : srfc_ref

	function automatic srfc_step_t srfc_next(input srfc_step_t s);
		return (s == STEP_C) ? STEP_B : (s == STEP_B) ? STEP_A : STEP_C;
	endfunction : srfc_next
endpackage : srfc_pkg
`default_nettype wire

// [design/srfc_mavg.sv]
// Moving average over the last 2**LOG2 accepted samples.
// Assumes samples arrive as single-cycle valid pulses; the average lags one cycle.
`timescale 1ns/1ns
`default_nettype none
module srfc_mavg #(
	parameter int W = 13,
	parameter int LOG2 = 3
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic in_valid,
	input wire logic signed [W-1:0] in_data,
	output logic signed [W-1:0] avg,
	output logic out_valid
);
	localparam int DEPTH = 2 ** LOG2;
	logic signed [W-1:0] mem_ff [DEPTH];
	logic signed [W+LOG2-1:0] sum_ff;
	logic signed [W+LOG2-1:0] nxt_sum;
	logic [LOG2-1:0] idx_ff;
	logic vld_ff;

	// Running sum swaps the oldest sample for the newest, so no adder tree is needed.
	always_comb
	begin
		nxt_sum = sum_ff + (W+LOG2)'(in_data) - (W+LOG2)'(mem_ff[idx_ff]);
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int k = 0; k < DEPTH; k++)
				mem_ff[k] <= '0;
			sum_ff <= '0;
			idx_ff <= '0;
			vld_ff <= 1'b0;
		end
		else
		begin
			vld_ff <= in_valid;
			if (in_valid)
			begin
				mem_ff[idx_ff] <= in_data;
				sum_ff <= nxt_sum;
				idx_ff <= idx_ff + 1'b1;
			end
		end
	end

	assign avg = W'(sum_ff >>> LOG2);
	assign out_valid = vld_ff;
endmodule : srfc_mavg
`default_nettype wire

// [design/srfc_flux_int.sv]
// Flux linkage integrator: each step adds the phase voltage less the resistive drop.
// Assumes volt, cur and res are stable in the step cycle; clear and load beat step.
`timescale 1ns/1ns
`default_nettype none
module srfc_flux_int #(
	parameter int FW = 24,
	parameter int CW = 14,
	parameter int UW = 13,
	parameter int RW = 16,
	parameter int RFRAC = 8
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic clear,
	input wire logic load,
	input wire logic signed [FW-1:0] load_val,
	input wire logic step,
	input wire logic signed [UW-1:0] volt,
	input wire logic signed [CW-1:0] cur,
	input wire logic [RW-1:0] res,
	output logic signed [FW-1:0] flux
);
	logic signed [FW-1:0] flux_ff;
	logic signed [FW-1:0] nxt_flux;
	logic signed [RW+CW:0] drop;

	// The resistance estimate enters every step, so a trimmed value acts at once.
	always_comb
	begin
		drop = $signed({1'b0, res}) * cur;
		nxt_flux = flux_ff;
		if (clear)
			nxt_flux = '0;
		else if (load)
			nxt_flux = load_val;
		else if (step)
			nxt_flux = flux_ff + FW'(volt) - FW'(drop >>> RFRAC);
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			flux_ff <= '0;
		else
			flux_ff <= nxt_flux;
	end

	assign flux = flux_ff;
endmodule : srfc_flux_int
`default_nettype wire

// [design/srfc_commutator.sv]
// Sensorless commutation core of a three-phase reluctance drive, stepped at the PWM rate.
// Assumes ADC results on pins held stable around the PWM centre strobe from same-clock logic.
`timescale 1ns/1ns
`default_nettype none
module srfc_commutator
	import srfc_pkg::*;
#(
	parameter int BUS_LOG2 = BUS_AVG_LOG2,
	parameter int ERR_LOG2 = ERR_AVG_LOG2
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic run_en,
	input wire logic pwm_centre,
	input wire logic [11:0] duty_req,
	input wire logic [11:0] speed_in,
	input wire logic signed [13:0] i_demand,
	input wire logic [11:0] adc_ia,
	input wire logic [11:0] adc_ib,
	input wire logic [11:0] adc_ic,
	input wire logic [11:0] adc_bus,
	input wire logic [11:0] adc_temp,
	output logic [2:0] high_pwm_en,
	output logic [2:0] low_on,
	output logic [11:0] duty_out,
	output logic commutate,
	output logic signed [13:0] phase_current,
	output logic [11:0] phase_voltage,
	output logic [11:0] bus_voltage,
	output logic signed [23:0] flux_est,
	output logic signed [23:0] flux_ref,
	output logic [15:0] res_est,
	output logic [7:0] comm_angle,
	output logic signed [11:0] temp_celsius
);
	// Pin synchroniser pairs, one per converter channel: a, b, c, bus, temperature.
	logic [11:0] adc_s1_ff [5];
	logic [11:0] adc_s2_ff [5];

	srfc_step_t step_ff, nxt_step;
	logic run_ff, nxt_run;
	logic full_ff, nxt_full;
	logic dis_on_ff, nxt_dis_on;
	logic [ANG_CNT_W-1:0] ang_cnt_ff, nxt_ang_cnt;
	logic [ANG_W-1:0] angle_ff, nxt_angle;
	logic [RES_W-1:0] res_ff, nxt_res;
	logic [11:0] duty_ff, nxt_duty;
	logic [2:0] high_ff, nxt_high;
	logic [2:0] low_ff, nxt_low;
	logic commut_ff;
	logic signed [13:0] cur_ff, nxt_cur;
	logic [11:0] volt_ff, nxt_volt;
	logic [11:0] bus_ff;
	logic signed [23:0] fref_ff;
	logic signed [11:0] temp_ff, nxt_temp;

	logic tick, start, hit, commut_req, latch_req;
	logic signed [CUR_W-1:0] smp [3];
	logic signed [CUR_W-1:0] i_act, i_dis;
	logic signed [VOLT_W-1:0] bus_avg, volt_act, volt_dis;
	logic [23:0] u_prod;
	logic signed [FLUX_W-1:0] flux_act, flux_dis, fref_calc, err_avg;
	logic err_vld;
	logic signed [10:0] ang_sum;
	logic [RES_W+20:0] res_prod;
	logic [RES_W-1:0] res_delta;
	logic signed [12:0] temp_diff;

	// Two flip-flops on every converter pin before any logic reads it.
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int k = 0; k < 5; k++)
			begin
				adc_s1_ff[k] <= '0;
				adc_s2_ff[k] <= '0;
			end
		end
		else
		begin
			adc_s1_ff[0] <= adc_ia;
			adc_s1_ff[1] <= adc_ib;
			adc_s1_ff[2] <= adc_ic;
			adc_s1_ff[3] <= adc_bus;
			adc_s1_ff[4] <= adc_temp;
			for (int k = 0; k < 5; k++)
				adc_s2_ff[k] <= adc_s1_ff[k];
		end
	end

	// Bus voltage filter, fed once per PWM period at the same strobe as the currents.
	srfc_mavg #(.W(VOLT_W), .LOG2(BUS_LOG2)) u_bus_avg (
		.core_clk(core_clk),
		.nrst(nrst),
		.in_valid(tick),
		.in_data($signed({1'b0, adc_s2_ff[3]})),
		.avg(bus_avg),
		.out_valid()
	);

	// Flux error filter; only the averaged error may trim the resistance.
	srfc_mavg #(.W(FLUX_W), .LOG2(ERR_LOG2)) u_err_avg (
		.core_clk(core_clk),
		.nrst(nrst),
		.in_valid(latch_req),
		.in_data(flux_dis),
		.avg(err_avg),
		.out_valid(err_vld)
	);

	// Powered-phase integrator, zeroed at start and at every commutation.
	srfc_flux_int #(.FW(FLUX_W), .CW(CUR_W), .UW(VOLT_W), .RW(RES_W), .RFRAC(RES_FRAC)) u_act_int (
		.core_clk(core_clk),
		.nrst(nrst),
		.clear(start | commut_req),
		.load(1'b0),
		.load_val('0),
		.step(tick & run_ff),
		.volt(volt_act),
		.cur(i_act),
		.res(res_ff),
		.flux(flux_act)
	);

	// Discharge integrator takes over the flux of the phase just switched off.
	srfc_flux_int #(.FW(FLUX_W), .CW(CUR_W), .UW(VOLT_W), .RW(RES_W), .RFRAC(RES_FRAC)) u_dis_int (
		.core_clk(core_clk),
		.nrst(nrst),
		.clear(start),
		.load(commut_req),
		.load_val(flux_act),
		.step(tick & dis_on_ff),
		.volt(volt_dis),
		.cur(i_dis),
		.res(res_ff),
		.flux(flux_dis)
	);

	// Measurement front end: mid-scale offset, reference subtraction and sign fix.
	always_comb
	begin
		tick = pwm_centre;
		start = run_en & ~run_ff;
		for (int k = 0; k < 3; k++)
			smp[k] = $signed({2'b00, adc_s2_ff[k]}) - $signed({2'b00, ADC_MID});
		i_act = smp[srfc_ref(step_ff)] - smp[srfc_act(step_ff)];
		i_dis = smp[srfc_dis(step_ff)] - smp[srfc_ref(step_ff)];
		u_prod = duty_ff * bus_avg[11:0];
		volt_act = $signed({1'b0, u_prod[23:12]});
		volt_dis = -bus_avg;
		fref_calc = FLUX_W'(i_act * $signed({1'b0, angle_ff}));
		hit = (fref_calc > 0) && (flux_act >= fref_calc);
		commut_req = tick & run_ff & run_en & hit;
		latch_req = tick & dis_on_ff & (i_dis <= I_ZERO_THR);
		ang_sum = $signed(ANGLE_BASE) + $signed({3'b000, speed_in[11:4]})
			+ 11'(i_demand >>> 5) - $signed({5'b00000, bus_avg[11:6]});
		res_prod = res_ff * 21'(RES_STEP_Q20);
		res_delta = (res_prod[RES_W+19:20] == '0) ? 16'h0001 : res_prod[RES_W+19:20];
		temp_diff = $signed({1'b0, adc_s2_ff[4]}) - $signed(TEMP_OFFSET);
	end

	// Next state of the commutation sequencer, trims and output registers.
	always_comb
	begin
		nxt_run = run_en;
		nxt_step = step_ff;
		nxt_full = full_ff;
		nxt_dis_on = dis_on_ff;
		nxt_ang_cnt = ang_cnt_ff;
		nxt_angle = angle_ff;
		nxt_res = res_ff;
		nxt_cur = cur_ff;
		nxt_volt = volt_ff;
		nxt_temp = temp_ff;
		if (start)
		begin
			nxt_step = STEP_C;
			nxt_full = 1'b1;
			nxt_dis_on = 1'b0;
		end
		else if (commut_req)
		begin
			nxt_step = srfc_next(step_ff);
			nxt_full = 1'b1;
		end
		else if (tick && i_act > i_demand)
			nxt_full = 1'b0;
		// A commutation in the same period as a latch re-arms discharge tracking.
		if (commut_req)
			nxt_dis_on = 1'b1;
		else if (latch_req)
			nxt_dis_on = 1'b0;
		if (tick && run_ff)
		begin
			nxt_ang_cnt = ang_cnt_ff - 1'b1;
			if (ang_cnt_ff == '0)
			begin
				nxt_ang_cnt = ANGLE_PERIOD;
				nxt_angle = (ang_sum < 0) ? '0 : (ang_sum > 11'sd255) ? 8'hff : ang_sum[7:0];
			end
		end
		if (err_vld)
			nxt_res = (err_avg > 0) ? res_ff + res_delta : res_ff - res_delta;
		if (tick)
		begin
			nxt_cur = i_act;
			nxt_volt = u_prod[23:12];
			nxt_temp = 12'(temp_diff / TEMP_SLOPE);
		end
		nxt_duty = (!run_en) ? 12'h000 : nxt_full ? DUTY_ONE : duty_req;
		nxt_low = (run_en && !start) || start ? 3'(1 << srfc_act(nxt_step)) : 3'b000;
		nxt_low = run_en ? nxt_low : 3'b000;
		nxt_high = nxt_low;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			run_ff <= 1'b0;
			step_ff <= STEP_C;
			full_ff <= 1'b0;
			dis_on_ff <= 1'b0;
			ang_cnt_ff <= '0;
			angle_ff <= ANGLE_BASE[7:0];
			res_ff <= RES_INIT;
			duty_ff <= '0;
			high_ff <= '0;
			low_ff <= '0;
			commut_ff <= 1'b0;
			cur_ff <= '0;
			volt_ff <= '0;
			bus_ff <= '0;
			fref_ff <= '0;
			temp_ff <= '0;
		end
		else
		begin
			run_ff <= nxt_run;
			step_ff <= nxt_step;
			full_ff <= nxt_full;
			dis_on_ff <= nxt_dis_on;
			ang_cnt_ff <= nxt_ang_cnt;
			angle_ff <= nxt_angle;
			res_ff <= nxt_res;
			duty_ff <= nxt_duty;
			high_ff <= nxt_high;
			low_ff <= nxt_low;
			commut_ff <= commut_req;
			cur_ff <= nxt_cur;
			volt_ff <= nxt_volt;
			bus_ff <= bus_avg[11:0];
			fref_ff <= fref_calc;
			temp_ff <= nxt_temp;
		end
	end

	assign high_pwm_en = high_ff;
	assign low_on = low_ff;
	assign duty_out = duty_ff;
	assign commutate = commut_ff;
	assign phase_current = cur_ff;
	assign phase_voltage = volt_ff;
	assign bus_voltage = bus_ff;
	assign flux_est = flux_act;
	assign flux_ref = fref_ff;
	assign res_est = res_ff;
	assign comm_angle = angle_ff;
	assign temp_celsius = temp_ff;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);

	sequence commut_seq;
		tick && run_ff && run_en && hit;
	endsequence

	sequence below_seq;
		tick && run_ff && !start && (flux_act < fref_calc);
	endsequence

	flux_clear_a: assert property (commut_seq |=> flux_act == 0)
		else $error("Flux accumulator not zero after commutation.");
	full_duty_a: assert property (commut_seq |=> duty_out == DUTY_ONE)
		else $error("New phase did not start at full duty.");
	rotate_step_a: assert property (commut_seq |=> step_ff == srfc_next($past(step_ff)))
		else $error("Phase roles did not rotate on commutation.");
	no_early_a: assert property (below_seq |=> !commutate)
		else $error("Commutated while flux below reference.");
	next_phase_a: assert property (commut_seq ##1 run_en |-> low_on == 3'(1 << srfc_act(step_ff)))
		else $error("Next phase not powered after commutation.");
	low_side_a: assert property (run_ff && run_en |-> $onehot(low_on) && high_pwm_en == low_on)
		else $error("Low side not held on the active phase.");
	res_up_a: assert property (err_vld && err_avg > 0 |=> res_est > $past(res_est))
		else $error("Resistance not raised on positive error.");
	res_down_a: assert property (err_vld && err_avg <= 0 |=> res_est < $past(res_est))
		else $error("Resistance not lowered on non-positive error.");
	dis_hold_a: assert property (commut_seq |=> dis_on_ff && flux_dis == $past(flux_act))
		else $error("Discharge flux not carried over.");
	cur_sample_a: assert property (tick |=> phase_current == $past(i_act))
		else $error("Phase current not taken at the strobe.");
endmodule : srfc_commutator
`default_nettype wire

// [tb/srfc_stage_model.sv]
// Behavioural power stage, phase shunts and converter channels facing the commutation core.
// Assumes the core's one-hot low_on marks the powered phase and that released phases decay at once.
`timescale 1ns/1ns
`default_nettype none
module srfc_stage_model
	import srfc_pkg::*;
(
	input wire logic [2:0] low_on,
	input wire logic [11:0] cur_level,
	input wire logic [11:0] noise,
	input wire logic [11:0] bus_level,
	input wire logic [11:0] temp_level,
	output logic [11:0] adc_ia,
	output logic [11:0] adc_ib,
	output logic [11:0] adc_ic,
	output logic [11:0] adc_bus,
	output logic [11:0] adc_temp
);
	logic [11:0] shunt [3];

	// Every phase shunt channel carries the same noise, so the unpowered phase reads noise alone.
	// The powered phase conducts through both switches, so its shunt reads cur_level below the other phases.
	always_comb
	begin
		for (int p = 0; p < 3; p++)
		begin
			shunt[p] = ADC_MID + noise;
			if (low_on[p])
			begin
				shunt[p] = shunt[p] - cur_level;
			end
		end
	end

	// Bus divider and temperature sense pass straight to the converter.
	assign adc_ia = shunt[0];
	assign adc_ib = shunt[1];
	assign adc_ic = shunt[2];
	assign adc_bus = bus_level;
	assign adc_temp = temp_level;
endmodule : srfc_stage_model
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the sensorless commutation core with a behavioural power stage.
// Assumes one 20 MHz clock; strobes are spaced so the two-flop converter sync always settles.
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import srfc_pkg::*;
;
	logic core_clk, nrst, run_en, pwm_centre;
	logic [11:0] duty_req, speed_in, cur_level, noise, bus_level, temp_level;
	logic signed [13:0] i_demand;
	logic [11:0] adc_ia, adc_ib, adc_ic, adc_bus, adc_temp;
	logic [2:0] high_pwm_en, low_on;
	logic [11:0] duty_out, phase_voltage, bus_voltage;
	logic commutate;
	logic signed [13:0] phase_current;
	logic signed [23:0] flux_est, flux_ref;
	logic [15:0] res_est;
	logic [7:0] comm_angle;
	logic signed [11:0] temp_celsius;
	int num_errors, compares, cycles;

	srfc_commutator dut (.core_clk(core_clk), .nrst(nrst), .run_en(run_en), .pwm_centre(pwm_centre),
		.duty_req(duty_req), .speed_in(speed_in), .i_demand(i_demand), .adc_ia(adc_ia), .adc_ib(adc_ib),
		.adc_ic(adc_ic), .adc_bus(adc_bus), .adc_temp(adc_temp), .high_pwm_en(high_pwm_en), .low_on(low_on),
		.duty_out(duty_out), .commutate(commutate), .phase_current(phase_current),
		.phase_voltage(phase_voltage), .bus_voltage(bus_voltage), .flux_est(flux_est), .flux_ref(flux_ref),
		.res_est(res_est), .comm_angle(comm_angle), .temp_celsius(temp_celsius));

	srfc_stage_model stage (.low_on(low_on), .cur_level(cur_level), .noise(noise), .bus_level(bus_level),
		.temp_level(temp_level), .adc_ia(adc_ia), .adc_ib(adc_ib), .adc_ic(adc_ic), .adc_bus(adc_bus),
		.adc_temp(adc_temp));

	// Free-running core clock at 50 ns.
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// Cycle ceiling well above the fewer than a thousand cycles the run needs, so a hang still ends the run.
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			give_verdict();
		end
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// One PWM centre pulse; noise moves after the strobe so each sample sees fresh common noise.
	task automatic strobe();
		repeat (4) @(posedge core_clk);
		pwm_centre <= 1'b1;
		@(posedge core_clk);
		pwm_centre <= 1'b0;
		noise <= noise + 12'h003;
		#1;
	endtask : strobe

	task automatic test_reset();
		check("res_est", 32'(RES_INIT), 32'(res_est));
		check("comm_angle", 32'h40, 32'(comm_angle));
		check("low_on", 32'h0, 32'(low_on));
		check("duty_out", 32'h0, 32'(duty_out));
	endtask : test_reset

	// Half a window of samples must show the zeros still in the average.
	task automatic test_filters();
		repeat (4) strobe();
		repeat (3) @(posedge core_clk);
		#1;
		check("bus half", 32'h200, 32'(bus_voltage));
		repeat (5) strobe();
		repeat (3) @(posedge core_clk);
		#1;
		check("bus full", 32'h400, 32'(bus_voltage));
		check("temp", (32'h264 - 32'(TEMP_OFFSET)) / TEMP_SLOPE, 32'(temp_celsius));
	endtask : test_filters

	// Run through four commutations, judging every strobe in between.
	task automatic test_run();
		logic [2:0] rot [3];
		logic signed [23:0] prev;
		int n;
		rot = '{3'b100, 3'b010, 3'b001};
		@(posedge core_clk);
		run_en <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		check("start low", 32'(rot[0]), 32'(low_on));
		check("start high", 32'(rot[0]), 32'(high_pwm_en));
		check("start duty", 32'(DUTY_ONE), 32'(duty_out));
		for (int k = 0; k < 4; k++)
		begin
			prev = '0;
			n = 0;
			strobe();
			while (commutate !== 1'b1 && n < 300)
			begin
				check("flux rise", 32'h1, 32'(flux_est > prev));
				check("i_act", 32'h100, 32'(phase_current));
				check("phase_voltage", (32'(DUTY_ONE) * 32'h400) >> 12, 32'(phase_voltage));
				prev = flux_est;
				n++;
				strobe();
			end
			check("commutate", 32'h1, 32'(commutate));
			check("low rot", 32'(rot[(k + 1) % 3]), 32'(low_on));
			check("high rot", 32'(rot[(k + 1) % 3]), 32'(high_pwm_en));
			check("flux clr", 32'h0, 32'(flux_est));
			check("new duty", 32'(DUTY_ONE), 32'(duty_out));
			@(posedge core_clk);
			#1;
			check("pulse", 32'h0, 32'(commutate));
		end
		repeat (2) strobe();
		check("angle", 32'h40 + (32'h100 >> 4) + (32'h400 >> 5) - (32'h400 >> 6), 32'(comm_angle));
		check("flux_ref", 32'h100 * 32'h60, 32'(flux_ref));
		// Four positive captures, each below the minimum step, so four single-step raises.
		check("res trim", 32'(RES_INIT) + 32'h4, 32'(res_est));
	endtask : test_run

	// Demand below the phase current hands the duty to the current controller.
	task automatic test_stop();
		@(posedge core_clk);
		i_demand <= 14'sh0080;
		strobe();
		check("reg duty", 32'(duty_req), 32'(duty_out));
		strobe();
		check("reg volt", (32'(duty_req) * 32'h400) >> 12, 32'(phase_voltage));
		@(posedge core_clk);
		run_en <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		check("stop low", 32'h0, 32'(low_on));
		check("stop duty", 32'h0, 32'(duty_out));
	endtask : test_stop

	task automatic give_verdict();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict

	// Demand is kept above the phase current so every new phase stays at full duty.
	initial
	begin
		nrst = 1'b0;
		run_en = 1'b0;
		pwm_centre = 1'b0;
		duty_req = 12'h800;
		speed_in = 12'h100;
		i_demand = 14'sh0400;
		cur_level = 12'h100;
		noise = 12'h005;
		bus_level = 12'h400;
		temp_level = 12'h264;
		num_errors = 0;
		compares = 0;
		repeat (16) @(posedge core_clk);
		test_reset();
		nrst <= 1'b1;
		repeat (3) @(posedge core_clk);
		test_filters();
		test_run();
		test_stop();
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
